// ---- hdl/flash_seq_pkg.sv ----
package flash_seq_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_KEY = 8'h00;
	localparam logic [7:0] REG_ECS = 8'h04;
	localparam logic [7:0] REG_DCS = 8'h08;
	localparam logic [7:0] REG_DTA = 8'h0C;
	localparam logic [7:0] REG_P0 = 8'h10;
	localparam logic [7:0] REG_P1 = 8'h14;
	localparam logic [7:0] REG_EP = 8'h18;
	localparam logic [7:0] REG_CALL = 8'h1C;
	localparam logic [7:0] REG_RES = 8'h20;
	localparam logic [7:0] REG_DLRES = 8'h24;
	localparam logic [7:0] REG_STAT = 8'h28;
	localparam logic [7:0] REG_IMASK = 8'h2C;
	// Key values
	localparam logic [7:0] KEY_DL = 8'hA5;
	localparam logic [7:0] KEY_PE = 8'h5A;
	// Routine entry offsets from the download start
	localparam logic [31:0] INIT_OFS = 32'h0000_0020;
	localparam logic [31:0] PROG_OFS = 32'h0000_0010;
	localparam int UNIT_LSB = 7;
	// Routine result bits
	localparam int RB_FREQ = 1;
	localparam int RB_ADDR = 2;
	localparam int RB_SRC = 3;
	localparam int RB_BLK = 4;
	localparam int RB_KEY = 5;
	localparam int RB_SEQ = 6;
	localparam int RB_BUS = 7;
	localparam logic [7:0] RES_OK = 8'h00;
	localparam logic [7:0] RES_RST = 8'hFF;
	// Download result bits
	localparam int DB_TD = 0;
	localparam int DB_FK = 1;
	localparam int DB_SS = 2;
	localparam logic [7:0] DL_OK = 8'h00;
	localparam logic [7:0] DL_RST = 8'hFF;
	// Field positions
	localparam int ECS_ERASE = 0;
	localparam int ECS_PROG = 1;
	localparam int DCS_REQ = 0;
	localparam int IM_CCR_I = 0;
	localparam int IM_LVL_LSB = 1;
	localparam int IM_MODE2 = 4;
	localparam logic [2:0] LVL_ALL = 3'h7;
	localparam int ST_BUSY = 0;
	localparam int ST_PROT = 1;
	localparam int ST_INIT = 2;
	localparam int ST_KIND = 3;
	localparam logic [31:0] FREQ_MIN = 32'h0000_0005;
	localparam logic [31:0] FREQ_MAX = 32'h0000_0021;
	// Defaults for sizes and timing counts
	localparam int NUM_IRQ_DEF = 8;
	localparam int DL_CYCLES_DEF = 16;
	localparam int PROG_CYCLES_DEF = 256;
	localparam int ERASE_CYCLES_DEF = 1024;
	localparam logic [31:0] UA_BASE_DEF = 32'h0000_0000;
	localparam logic [31:0] UA_SIZE_DEF = 32'h0002_0000;
	localparam logic [31:0] RAM_BASE_DEF = 32'h00FF_0000;
	localparam logic [31:0] RAM_SIZE_DEF = 32'h0000_8000;
	localparam logic [31:0] NUM_BLOCKS_DEF = 32'h0000_0008;

	typedef enum logic [1:0] {RT_NONE, RT_PROG, RT_ERASE} routine_t;

	typedef struct packed {
		logic done;
		routine_t kind;
		logic [7:0] result;
	} dl_status_t;

	function automatic logic in_window(input logic [31:0] a, input logic [31:0] base,
		input logic [31:0] size);
		return (a >= base) && ((a - base) < size);
	endfunction
endpackage

// ---- hdl/download_unit.sv ----
`timescale 1ns/1ps
module download_unit #(
	parameter int DL_CYCLES = flash_seq_pkg::DL_CYCLES_DEF,
	parameter logic [31:0] RAM_BASE = flash_seq_pkg::RAM_BASE_DEF,
	parameter logic [31:0] RAM_SIZE = flash_seq_pkg::RAM_SIZE_DEF
)(
	input wire logic mclk, // Clock
	input wire logic sys_rst, // Sync reset
	input wire logic req, // Download request level
	input wire logic prog_sel, // Programming routine selected
	input wire logic erase_sel, // Erase routine selected
	input wire logic [7:0] key, // Flash key value
	input wire logic [31:0] target, // Download target address
	output flash_seq_pkg::dl_status_t status // Done pulse, kind, result
);
	typedef enum logic [1:0] {D_IDLE, D_RUN, D_HOLD} dl_state_t;
	dl_state_t state_r, state_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [7:0] err_r, err_nxt;
	flash_seq_pkg::routine_t kind_r, kind_nxt;
	flash_seq_pkg::dl_status_t status_nxt;

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		err_nxt = err_r;
		kind_nxt = kind_r;
		status_nxt = '0;
		status_nxt.result = status.result;
		status_nxt.kind = status.kind;
		unique case (state_r)
			D_IDLE:
				if (req)
				begin
					err_nxt = '0;
					err_nxt[flash_seq_pkg::DB_SS] = (prog_sel == erase_sel);
					err_nxt[flash_seq_pkg::DB_FK] = (key != flash_seq_pkg::KEY_DL);
					err_nxt[flash_seq_pkg::DB_TD] = !flash_seq_pkg::in_window(target,
						RAM_BASE, RAM_SIZE);
					kind_nxt = erase_sel ? flash_seq_pkg::RT_ERASE : flash_seq_pkg::RT_PROG;
					cnt_nxt = '0;
					state_nxt = D_RUN;
				end
			D_RUN:
				if (cnt_r == 32'(DL_CYCLES - 1))
				begin
					status_nxt.done = 1'b1;
					status_nxt.result = err_r;
					status_nxt.kind = (err_r == flash_seq_pkg::DL_OK) ? kind_r :
						flash_seq_pkg::RT_NONE;
					state_nxt = D_HOLD;
				end
				else
					cnt_nxt = cnt_r + 32'd1;
			D_HOLD:
				if (!req)
					state_nxt = D_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state_r <= D_IDLE;
			cnt_r <= '0;
			err_r <= '0;
			kind_r <= flash_seq_pkg::RT_NONE;
			status <= '{done: 1'b0, kind: flash_seq_pkg::RT_NONE, result: flash_seq_pkg::DL_RST};
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			err_r <= err_nxt;
			kind_r <= kind_nxt;
			status <= status_nxt;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	property p_sel_err;
		(state_r == D_IDLE && req && prog_sel && erase_sel) |=>
			(state_r == D_RUN) && err_r[flash_seq_pkg::DB_SS];
	endproperty
	property p_sel_kind;
		status.done && status.result[flash_seq_pkg::DB_SS] |-> status.kind == flash_seq_pkg::RT_NONE;
	endproperty
	property p_dl_ok;
		status.done |-> ((status.result == flash_seq_pkg::DL_OK) ==
			(status.kind != flash_seq_pkg::RT_NONE));
	endproperty
	a_sel_err: assert property (p_sel_err) else $error("select error not captured");
	a_sel_kind: assert property (p_sel_kind) else $error("download done despite select error");
	a_dl_ok: assert property (p_dl_ok) else $error("download result and kind disagree");
endmodule

// ---- hdl/irq_hold.sv ----
`timescale 1ns/1ps
module irq_hold #(
	parameter int NUM_IRQ = flash_seq_pkg::NUM_IRQ_DEF
)(
	input wire logic mclk, // Clock
	input wire logic sys_rst, // Sync reset
	input wire logic mask_on, // Interrupt mask in force
	input wire logic [NUM_IRQ-1:0] irq_req, // Maskable requests
	input wire logic nmi_req, // Non-maskable request
	output logic [NUM_IRQ-1:0] irq_out, // Requests passed to the core
	output logic nmi_out // Non-maskable request passed on
);
	logic [NUM_IRQ-1:0] pending_r, pending_nxt, irq_out_nxt;

	always_comb
	begin
		if (mask_on)
		begin
			pending_nxt = pending_r | irq_req;
			irq_out_nxt = '0;
		end
		else
		begin
			pending_nxt = '0;
			irq_out_nxt = pending_r | irq_req;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			pending_r <= '0;
			irq_out <= '0;
			nmi_out <= 1'b0;
		end
		else
		begin
			pending_r <= pending_nxt;
			irq_out <= irq_out_nxt;
			nmi_out <= nmi_req;
		end
	end

	property p_held;
		@(posedge mclk) disable iff (sys_rst) mask_on |=> irq_out == '0;
	endproperty
	property p_release;
		@(posedge mclk) disable iff (sys_rst)
		(!mask_on && pending_r != '0) |=> (irq_out & $past(pending_r)) == $past(pending_r);
	endproperty
	a_held: assert property (p_held) else $error("interrupt passed while masked");
	a_release: assert property (p_release) else $error("held interrupt lost");
endmodule

// ---- hdl/flash_user_program_erase_control.sv ----
`timescale 1ns/1ps
module flash_user_program_erase_control #(
	parameter int NUM_IRQ = flash_seq_pkg::NUM_IRQ_DEF,
	parameter int DL_CYCLES = flash_seq_pkg::DL_CYCLES_DEF,
	parameter int PROG_CYCLES = flash_seq_pkg::PROG_CYCLES_DEF,
	parameter int ERASE_CYCLES = flash_seq_pkg::ERASE_CYCLES_DEF,
	parameter logic [31:0] UA_BASE = flash_seq_pkg::UA_BASE_DEF,
	parameter logic [31:0] UA_SIZE = flash_seq_pkg::UA_SIZE_DEF,
	parameter logic [31:0] RAM_BASE = flash_seq_pkg::RAM_BASE_DEF,
	parameter logic [31:0] RAM_SIZE = flash_seq_pkg::RAM_SIZE_DEF,
	parameter logic [31:0] NUM_BLOCKS = flash_seq_pkg::NUM_BLOCKS_DEF
)(
	input wire logic mclk, // 25 MHz clock
	input wire logic sys_rst, // Sync reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic dma_grant, // Bus held by direct_memory_access_ctrl
	input wire logic [NUM_IRQ-1:0] irq_req, // Maskable requests in
	input wire logic nmi_req, // Non-maskable request in
	output logic [NUM_IRQ-1:0] irq_out, // Maskable requests out
	output logic nmi_out, // Non-maskable request out
	output logic busy, // Download or routine in progress
	output logic err_protect // Error protection state
);
	typedef enum logic [0:0] {S_IDLE, S_RUN} seq_state_t;

	function automatic logic is_entry(input logic [31:0] ep, input logic [31:0] top,
		input logic [31:0] ofs);
		return ep == top + ofs;
	endfunction

	logic acc, wr_go, known, call_go, init_hit, prog_hit, freq_ok, mask_on;
	logic [31:0] rdata, run_lim;
	logic [7:0] chk_err;
	logic pready_nxt, pslverr_nxt;
	logic [31:0] prdata_nxt;
	logic [7:0] key_r, key_nxt;
	logic [1:0] ecs_r, ecs_nxt;
	logic dl_req_r, dl_req_nxt;
	logic [31:0] dta_r, dta_nxt, p0_r, p0_nxt, p1_r, p1_nxt, ep_r, ep_nxt;
	logic [4:0] imask_r, imask_nxt;
	seq_state_t state_r, state_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [7:0] result_r, result_nxt, dlres_r, dlres_nxt;
	logic init_r, init_nxt, prot_r, prot_nxt, busy_nxt;
	flash_seq_pkg::routine_t kind_r, kind_nxt;
	flash_seq_pkg::dl_status_t dl_stat;

	assign acc = psel & penable;
	assign wr_go = acc & pwrite & pready;
	assign call_go = wr_go && (paddr == flash_seq_pkg::REG_CALL) && (state_r == S_IDLE)
		&& !dl_req_r;
	assign init_hit = is_entry(ep_r, dta_r, flash_seq_pkg::INIT_OFS);
	assign prog_hit = is_entry(ep_r, dta_r, flash_seq_pkg::PROG_OFS);
	assign freq_ok = (p0_r >= flash_seq_pkg::FREQ_MIN) && (p0_r <= flash_seq_pkg::FREQ_MAX);
	assign mask_on = imask_r[flash_seq_pkg::IM_MODE2] ?
		(imask_r[flash_seq_pkg::IM_LVL_LSB +: 3] == flash_seq_pkg::LVL_ALL) :
		imask_r[flash_seq_pkg::IM_CCR_I];
	assign run_lim = (kind_r == flash_seq_pkg::RT_ERASE) ? 32'(ERASE_CYCLES - 1) :
		32'(PROG_CYCLES - 1);

	// --------------------------------------------------------------
	// Register read decode and APB answer
	// --------------------------------------------------------------
	always_comb
	begin
		known = 1'b1;
		rdata = '0;
		case (paddr)
			flash_seq_pkg::REG_KEY: rdata[7:0] = key_r;
			flash_seq_pkg::REG_ECS: rdata[1:0] = ecs_r;
			flash_seq_pkg::REG_DCS: rdata[flash_seq_pkg::DCS_REQ] = dl_req_r;
			flash_seq_pkg::REG_DTA: rdata = dta_r;
			flash_seq_pkg::REG_P0: rdata = p0_r;
			flash_seq_pkg::REG_P1: rdata = p1_r;
			flash_seq_pkg::REG_EP: rdata = ep_r;
			flash_seq_pkg::REG_CALL: rdata = '0;
			flash_seq_pkg::REG_RES: rdata[7:0] = result_r;
			flash_seq_pkg::REG_DLRES: rdata[7:0] = dlres_r;
			flash_seq_pkg::REG_STAT:
			begin
				rdata[flash_seq_pkg::ST_BUSY] = busy;
				rdata[flash_seq_pkg::ST_PROT] = prot_r;
				rdata[flash_seq_pkg::ST_INIT] = init_r;
				rdata[flash_seq_pkg::ST_KIND +: 2] = kind_r;
			end
			flash_seq_pkg::REG_IMASK: rdata[4:0] = imask_r;
			default: known = 1'b0;
		endcase
		pready_nxt = acc & ~pready;
		pslverr_nxt = acc & ~pready & ~known;
		prdata_nxt = (acc & ~pready & ~pwrite) ? rdata : prdata;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= pready_nxt;
			pslverr <= pslverr_nxt;
			prdata <= prdata_nxt;
		end
	end

	// --------------------------------------------------------------
	// Software registers
	// --------------------------------------------------------------
	always_comb
	begin
		key_nxt = key_r;
		ecs_nxt = ecs_r;
		dl_req_nxt = dl_req_r;
		dta_nxt = dta_r;
		p0_nxt = p0_r;
		p1_nxt = p1_r;
		ep_nxt = ep_r;
		imask_nxt = imask_r;
		if (dl_stat.done)
			dl_req_nxt = 1'b0;
		if (wr_go)
		begin
			case (paddr)
				flash_seq_pkg::REG_KEY: key_nxt = pwdata[7:0];
				flash_seq_pkg::REG_ECS: ecs_nxt = pwdata[1:0];
				flash_seq_pkg::REG_DCS:
					if (pwdata[flash_seq_pkg::DCS_REQ] && key_r == flash_seq_pkg::KEY_DL
						&& !busy)
						dl_req_nxt = 1'b1;
				flash_seq_pkg::REG_IMASK: imask_nxt = pwdata[4:0];
				default:
					// Parameters are frozen while a routine owns them
					if (!busy)
					begin
						if (paddr == flash_seq_pkg::REG_DTA)
							dta_nxt = pwdata;
						if (paddr == flash_seq_pkg::REG_P0)
							p0_nxt = pwdata;
						if (paddr == flash_seq_pkg::REG_P1)
							p1_nxt = pwdata;
						if (paddr == flash_seq_pkg::REG_EP)
							ep_nxt = pwdata;
					end
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			key_r <= '0;
			ecs_r <= '0;
			dl_req_r <= 1'b0;
			dta_r <= '0;
			p0_r <= '0;
			p1_r <= '0;
			ep_r <= '0;
			imask_r <= '0;
		end
		else
		begin
			key_r <= key_nxt;
			ecs_r <= ecs_nxt;
			dl_req_r <= dl_req_nxt;
			dta_r <= dta_nxt;
			p0_r <= p0_nxt;
			p1_r <= p1_nxt;
			ep_r <= ep_nxt;
			imask_r <= imask_nxt;
		end
	end

	// --------------------------------------------------------------
	// Routine sequencer
	// --------------------------------------------------------------
	localparam int UNIT_BITS = flash_seq_pkg::UNIT_LSB;

	always_comb
	begin
		chk_err = '0;
		chk_err[flash_seq_pkg::RB_KEY] = (key_r != flash_seq_pkg::KEY_PE);
		chk_err[flash_seq_pkg::RB_SEQ] = !init_r;
		chk_err[flash_seq_pkg::RB_BUS] = prot_r;
		if (kind_r == flash_seq_pkg::RT_PROG)
		begin
			chk_err[flash_seq_pkg::RB_ADDR] = !flash_seq_pkg::in_window(p1_r, UA_BASE, UA_SIZE)
				|| (p1_r[UNIT_BITS-1:0] != '0);
			chk_err[flash_seq_pkg::RB_SRC] = flash_seq_pkg::in_window(p0_r, UA_BASE,
				UA_SIZE);
		end
		else
			chk_err[flash_seq_pkg::RB_BLK] = (p0_r >= NUM_BLOCKS);
	end

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		result_nxt = result_r;
		dlres_nxt = dlres_r;
		init_nxt = init_r;
		prot_nxt = prot_r;
		kind_nxt = kind_r;
		if (dl_stat.done)
		begin
			dlres_nxt = dl_stat.result;
			kind_nxt = dl_stat.kind;
			init_nxt = 1'b0;
		end
		unique case (state_r)
			S_IDLE:
				if (call_go)
				begin
					if (kind_r == flash_seq_pkg::RT_NONE)
						result_nxt = 8'h40;
					else if (init_hit)
					begin
						result_nxt = freq_ok ? flash_seq_pkg::RES_OK : 8'h02;
						init_nxt = freq_ok;
					end
					else if (prog_hit && chk_err != '0)
						result_nxt = chk_err;
					else if (prog_hit)
					begin
						// One block or one 128-byte unit per call
						state_nxt = S_RUN;
						cnt_nxt = '0;
					end
					else
						result_nxt = 8'h40;
				end
			S_RUN:
				if (dma_grant)
				begin
					prot_nxt = 1'b1;
					result_nxt = 8'h80;
					state_nxt = S_IDLE;
				end
				else if (cnt_r == run_lim)
				begin
					result_nxt = flash_seq_pkg::RES_OK;
					state_nxt = S_IDLE;
				end
				else
					cnt_nxt = cnt_r + 32'd1;
		endcase
		busy_nxt = (state_nxt == S_RUN) || dl_req_nxt;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state_r <= S_IDLE;
			cnt_r <= '0;
			result_r <= flash_seq_pkg::RES_RST;
			dlres_r <= flash_seq_pkg::DL_RST;
			init_r <= 1'b0;
			prot_r <= 1'b0;
			kind_r <= flash_seq_pkg::RT_NONE;
			busy <= 1'b0;
			err_protect <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			result_r <= result_nxt;
			dlres_r <= dlres_nxt;
			init_r <= init_nxt;
			prot_r <= prot_nxt;
			kind_r <= kind_nxt;
			busy <= busy_nxt;
			err_protect <= prot_nxt;
		end
	end

	download_unit #(.DL_CYCLES(DL_CYCLES), .RAM_BASE(RAM_BASE), .RAM_SIZE(RAM_SIZE)) u_dl (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.req(dl_req_r),
		.prog_sel(ecs_r[flash_seq_pkg::ECS_PROG]),
		.erase_sel(ecs_r[flash_seq_pkg::ECS_ERASE]),
		.key(key_r),
		.target(dta_r),
		.status(dl_stat)
	);

	irq_hold #(.NUM_IRQ(NUM_IRQ)) u_irq (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.mask_on(mask_on),
		.irq_req(irq_req),
		.nmi_req(nmi_req),
		.irq_out(irq_out),
		.nmi_out(nmi_out)
	);

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	property p_dl_key;
		$rose(dl_req_r) |-> $past(key_r) == flash_seq_pkg::KEY_DL;
	endproperty
	property p_init_ok;
		call_go && kind_r != flash_seq_pkg::RT_NONE && init_hit && freq_ok
			|=> init_r && result_r == flash_seq_pkg::RES_OK;
	endproperty
	property p_prog_entry;
		call_go && kind_r != flash_seq_pkg::RT_NONE && !init_hit && prog_hit && chk_err == '0
			|=> state_r == S_RUN && busy;
	endproperty
	property p_gpr_keep;
		state_r == S_RUN |=> $stable(p0_r) && $stable(p1_r) && $stable(ep_r);
	endproperty
	property p_dma_prot;
		state_r == S_RUN && dma_grant |=> err_protect && result_r[flash_seq_pkg::RB_BUS]
			&& state_r == S_IDLE;
	endproperty
	property p_bad_dest;
		call_go && kind_r == flash_seq_pkg::RT_PROG && prog_hit && !init_hit
			&& !flash_seq_pkg::in_window(p1_r, UA_BASE, UA_SIZE)
			|=> (state_r == S_IDLE && result_r[flash_seq_pkg::RB_ADDR]) [*2];
	endproperty
	property p_src_flash;
		call_go && kind_r == flash_seq_pkg::RT_PROG && prog_hit && !init_hit
			&& flash_seq_pkg::in_window(p0_r, UA_BASE, UA_SIZE)
			|=> state_r == S_IDLE && result_r != flash_seq_pkg::RES_OK;
	endproperty
	property p_bad_block;
		call_go && kind_r == flash_seq_pkg::RT_ERASE && prog_hit && !init_hit
			&& p0_r >= NUM_BLOCKS |=> state_r == S_IDLE && result_r[flash_seq_pkg::RB_BLK];
	endproperty

	a_dl_key: assert property (p_dl_key) else $error("download request without key");
	a_init_ok: assert property (p_init_ok) else $error("initialization not completed");
	a_prog_entry: assert property (p_prog_entry) else $error("valid call did not start");
	a_gpr_keep: assert property (p_gpr_keep) else $error("parameters changed while running");
	a_dma_prot: assert property (p_dma_prot) else $error("bus takeover not protected");
	a_bad_dest: assert property (p_bad_dest) else $error("bad destination accepted");
	a_src_flash: assert property (p_src_flash) else $error("flash source accepted");
	a_bad_block: assert property (p_bad_block) else $error("bad block accepted");

	c_download: cover property (dl_stat.done && dl_stat.result == flash_seq_pkg::DL_OK);
	c_program: cover property (state_r == S_RUN && kind_r == flash_seq_pkg::RT_PROG
		##1 state_r == S_IDLE && result_r == flash_seq_pkg::RES_OK);
	c_erase: cover property (state_r == S_RUN && kind_r == flash_seq_pkg::RT_ERASE
		##1 state_r == S_IDLE);
	c_dma: cover property (state_r == S_RUN && dma_grant);
endmodule

// ---- testbench/flash_user_program_erase_control_tb_top.sv ----
`timescale 1ns/1ps
module flash_user_program_erase_control_tb_top;
	localparam logic [31:0] RB = flash_seq_pkg::RAM_BASE_DEF;
	localparam logic [31:0] EB = RB + 32'h0000_1000;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic dma_grant = 1'b0;
	logic [7:0] irq_req = 8'h00;
	logic nmi_req = 1'b0; // Held low while programming
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] irq_out;
	logic nmi_out;
	logic busy;
	logic err_protect;
	logic [31:0] q;
	logic serr;
	logic seen;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;

	always #20 mclk = ~mclk;

	flash_user_program_erase_control #(.DL_CYCLES(4), .PROG_CYCLES(8), .ERASE_CYCLES(8)) dut (
		.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dma_grant(dma_grant), .irq_req(irq_req), .nmi_req(nmi_req), .irq_out(irq_out),
		.nmi_out(nmi_out), .busy(busy), .err_protect(err_protect));

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------
	// Hang guard
	// ----------------------------------------
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches++;
			final_report();
		end
	end

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, e, q);
	endtask

	task automatic wait_idle();
		repeat (2) @(posedge mclk);
		for (int i = 0; i < 60 && busy !== 1'b0; i++) @(posedge mclk);
	endtask

	task automatic dl(input logic [31:0] sel, input logic [31:0] tgt);
		apb(1'b1, flash_seq_pkg::REG_ECS, sel);
		apb(1'b1, flash_seq_pkg::REG_DTA, tgt);
		apb(1'b1, flash_seq_pkg::REG_DCS, 32'h0000_0001);
		wait_idle();
	endtask

	task automatic call(input logic [31:0] p0, input logic [31:0] p1, input logic [31:0] ep,
		input logic [31:0] e);
		apb(1'b1, flash_seq_pkg::REG_P0, p0);
		apb(1'b1, flash_seq_pkg::REG_P1, p1);
		apb(1'b1, flash_seq_pkg::REG_EP, ep);
		apb(1'b1, flash_seq_pkg::REG_CALL, 32'h0000_0000);
		wait_idle();
		rdc(flash_seq_pkg::REG_RES, e, "result");
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		rdc(flash_seq_pkg::REG_RES, 32'h0000_00FF, "result reset");
		rdc(flash_seq_pkg::REG_DLRES, 32'h0000_00FF, "download reset");
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, {31'h0000_0000, serr});
		dl(32'h0000_0002, RB);
		rdc(flash_seq_pkg::REG_DLRES, 32'h0000_00FF, "locked request");
		$display("test download lock done");
		apb(1'b1, flash_seq_pkg::REG_KEY, 32'h0000_00A5);
		dl(32'h0000_0003, RB);
		rdc(flash_seq_pkg::REG_DLRES, 32'h0000_0004, "select error");
		dl(32'h0000_0002, RB); // Stack and routine space kept clear
		rdc(flash_seq_pkg::REG_DLRES, 32'h0000_0000, "download ok");
		call(32'h0000_0014, 32'h0000_0000, RB + 32'h0000_0020, 32'h0000_0000);
		$display("test download done");
		call(RB, 32'h0000_0100, RB + 32'h0000_0010, 32'h0000_0020);
		apb(1'b1, flash_seq_pkg::REG_KEY, 32'h0000_005A);
		call(RB, 32'h0002_0000, RB + 32'h0000_0010, 32'h0000_0004);
		call(RB, 32'h0000_0140, RB + 32'h0000_0010, 32'h0000_0004);
		call(32'h0000_0200, 32'h0000_0100, RB + 32'h0000_0010, 32'h0000_0008);
		apb(1'b1, flash_seq_pkg::REG_IMASK, 32'h0000_001E);
		irq_req <= 8'h05;
		call(RB, 32'h0000_0180, RB + 32'h0000_0010, 32'h0000_0000);
		chk("held irq", 32'h0000_0000, {24'h00_0000, irq_out});
		rdc(flash_seq_pkg::REG_P1, 32'h0000_0180, "kept param");
		call(RB, 32'h0000_0200, RB + 32'h0000_0010, 32'h0000_0000);
		irq_req <= 8'h00;
		apb(1'b1, flash_seq_pkg::REG_IMASK, 32'h0000_0000);
		seen = 1'b0;
		repeat (4)
		begin
			@(posedge mclk);
			if (irq_out === 8'h05)
				seen = 1'b1;
		end
		chk("released irq", 32'h0000_0001, {31'h0000_0000, seen});
		apb(1'b1, flash_seq_pkg::REG_KEY, 32'h0000_0000);
		nmi_req <= 1'b1;
		repeat (2) @(posedge mclk);
		chk("nmi passed", 32'h0000_0001, {31'h0000_0000, nmi_out});
		nmi_req <= 1'b0;
		$display("test program done");
		apb(1'b1, flash_seq_pkg::REG_KEY, 32'h0000_00A5);
		dl(32'h0000_0001, EB);
		rdc(flash_seq_pkg::REG_DLRES, 32'h0000_0000, "erase download");
		call(32'h0000_0014, 32'h0000_0000, EB + 32'h0000_0020, 32'h0000_0000);
		apb(1'b1, flash_seq_pkg::REG_KEY, 32'h0000_005A);
		call(32'h0000_0008, 32'h0000_0000, EB + 32'h0000_0010, 32'h0000_0010);
		call(32'h0000_0007, 32'h0000_0000, EB + 32'h0000_0010, 32'h0000_0000);
		$display("test erase done");
		apb(1'b1, flash_seq_pkg::REG_P0, 32'h0000_0001);
		apb(1'b1, flash_seq_pkg::REG_CALL, 32'h0000_0000);
		repeat (3) @(posedge mclk);
		chk("busy", 32'h0000_0001, {31'h0000_0000, busy});
		dma_grant <= 1'b1;
		wait_idle();
		dma_grant <= 1'b0;
		rdc(flash_seq_pkg::REG_RES, 32'h0000_0080, "bus taken");
		chk("protect", 32'h0000_0001, {31'h0000_0000, err_protect});
		rdc(flash_seq_pkg::REG_STAT, 32'h0000_0016, "status");
		$display("test bus master done");
		final_report();
	end
endmodule
